// [scgr_sleep_gate.sv]
// sleep clock gating register, wishbone slave and unit clock gates
//
// Decided for this implementation: the Wishbone slave port and the register addresses other than the sleep gating offset 0x118.
`timescale 1ns/10ps
module scgr_sleep_gate
#(
  parameter int UNITS = scgr_pkg::UNIT_N
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [scgr_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [scgr_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [scgr_pkg::DATA_W-1:0] wb_dat_i,
  output logic [scgr_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // system power state
  input wire logic sleep_i,
  input wire logic [UNITS-1:0] run_enable_i,
  // controlled units
  input wire logic [UNITS-1:0] unit_access_i,
  output logic [UNITS-1:0] unit_fault_o,
  output logic [UNITS-1:0] unit_enable_o,
  output logic [UNITS-1:0] unit_clk_o,
  // interrupt
  output logic irq_o
);

  // register contents
  logic [scgr_pkg::DATA_W-1:0] sleep_gating_reg;
  logic [scgr_pkg::DATA_W-1:0] next_sleep_gating_reg;
  logic auto_clock_gating;
  logic next_auto_clock_gating;
  logic [UNITS-1:0] fault_status;
  logic [UNITS-1:0] next_fault_status;
  logic [UNITS-1:0] fault_mask;
  logic [UNITS-1:0] next_fault_mask;

  // bus answer state
  scgr_pkg::scgr_bus_state_t bus_state;
  scgr_pkg::scgr_bus_state_t next_bus_state;
  logic [scgr_pkg::DATA_W-1:0] rd_data;
  logic [scgr_pkg::DATA_W-1:0] next_rd_data;

  // sleep synchroniser and effective enables
  logic [scgr_pkg::SYNC_STAGES-1:0] sleep_sync;
  logic [scgr_pkg::SYNC_STAGES-1:0] next_sleep_sync;
  logic sleep_active;
  logic [UNITS-1:0] sleep_units;
  logic [UNITS-1:0] wanted_enable;
  logic [UNITS-1:0] enable_q;
  logic [UNITS-1:0] next_enable_q;

  // decode helpers
  logic bus_req;
  logic bus_wr;
  logic hit_ctrl;
  logic hit_status;
  logic hit_mask;
  logic hit_active;
  logic hit_sleep;
  logic hit_any;
  logic [scgr_pkg::DATA_W-1:0] byte_mask;
  logic [scgr_pkg::DATA_W-1:0] wr_word;

  // pick the unit bits out of a register-layout word
  function automatic logic [UNITS-1:0] word_to_units
  (
    input logic [scgr_pkg::DATA_W-1:0] word
  );
    logic [UNITS-1:0] u;
    u = '0;
    u[scgr_pkg::PORT_N-1:0] = word[scgr_pkg::PORT_H_CLOCK_GATE_BIT:
                                   scgr_pkg::PORT_A_CLOCK_GATE_BIT]; // see R5
    u[scgr_pkg::UNIT_MAC] = word[scgr_pkg::MAC_CLOCK_GATE_BIT]; // see R4
    u[scgr_pkg::UNIT_PHY] = word[scgr_pkg::PHY_CLOCK_GATE_BIT]; // see R3
    return u;
  endfunction : word_to_units

  // place unit bits back into the register layout
  function automatic logic [scgr_pkg::DATA_W-1:0] units_to_word
  (
    input logic [UNITS-1:0] u
  );
    logic [scgr_pkg::DATA_W-1:0] w;
    w = scgr_pkg::ZERO_WORD;
    w[scgr_pkg::PORT_H_CLOCK_GATE_BIT:scgr_pkg::PORT_A_CLOCK_GATE_BIT] =
      u[scgr_pkg::PORT_N-1:0];
    w[scgr_pkg::MAC_CLOCK_GATE_BIT] = u[scgr_pkg::UNIT_MAC];
    w[scgr_pkg::PHY_CLOCK_GATE_BIT] = u[scgr_pkg::UNIT_PHY];
    return w;
  endfunction : units_to_word

  // address decode; only a request not yet answered is taken
  always_comb
  begin
    bus_req = wb_cyc_i & wb_stb_i & (bus_state == scgr_pkg::SCGR_IDLE);
    bus_wr = bus_req & wb_we_i;
    hit_ctrl = (wb_adr_i == scgr_pkg::CTRL_OFFSET);
    hit_status = (wb_adr_i == scgr_pkg::FAULT_STATUS_OFFSET);
    hit_mask = (wb_adr_i == scgr_pkg::FAULT_MASK_OFFSET);
    hit_active = (wb_adr_i == scgr_pkg::ACTIVE_OFFSET);
    hit_sleep = (wb_adr_i == scgr_pkg::SLEEP_GATING_OFFSET); // see R11
    hit_any = hit_ctrl | hit_status | hit_mask | hit_active | hit_sleep;
  end

  // byte lanes turned into a bit mask
  always_comb
  begin
    for (int i = 0; i < scgr_pkg::SEL_W; i++)
    begin
      byte_mask[i*8 +: 8] = {8{wb_sel_i[i]}};
    end
    wr_word = wb_dat_i & byte_mask;
  end

  // sleep gating register: only the documented bits can be written
  always_comb
  begin
    next_sleep_gating_reg = sleep_gating_reg;
    if (rst_i)
    begin
      next_sleep_gating_reg = scgr_pkg::SLEEP_GATING_RESET; // see R8
    end
    else if (bus_wr && hit_sleep)
    begin
      // reserved bits are dropped so they always read zero
      next_sleep_gating_reg =
        ((sleep_gating_reg & ~byte_mask) | wr_word)
        & scgr_pkg::SLEEP_GATING_WMASK; // see R1
    end
  end

  always_ff @(posedge clk_i)
  begin
    sleep_gating_reg <= next_sleep_gating_reg;
  end

  // control register: the auto clock gating switch
  always_comb
  begin
    next_auto_clock_gating = auto_clock_gating;
    if (rst_i)
    begin
      next_auto_clock_gating = 1'b0;
    end
    else if (bus_wr && hit_ctrl && wb_sel_i[0])
    begin
      next_auto_clock_gating = wb_dat_i[scgr_pkg::AUTO_CLOCK_GATING_BIT];
    end
  end

  always_ff @(posedge clk_i)
  begin
    auto_clock_gating <= next_auto_clock_gating;
  end

  // fault mask register, same layout as the gating register
  always_comb
  begin
    next_fault_mask = fault_mask;
    if (rst_i)
    begin
      next_fault_mask = '0;
    end
    else if (bus_wr && hit_mask)
    begin
      next_fault_mask = word_to_units(
        (units_to_word(fault_mask) & ~byte_mask) | wr_word);
    end
  end

  always_ff @(posedge clk_i)
  begin
    fault_mask <= next_fault_mask;
  end

  // sticky fault status; a new fault beats a write-one clear
  always_comb
  begin
    next_fault_status = fault_status;
    if (rst_i)
    begin
      next_fault_status = '0;
    end
    else
    begin
      if (bus_wr && hit_status)
      begin
        next_fault_status = fault_status & ~word_to_units(wr_word);
      end
      next_fault_status = next_fault_status | unit_fault_o;
    end
  end

  always_ff @(posedge clk_i)
  begin
    fault_status <= next_fault_status;
  end

  // sleep level comes from another domain, so two flops first
  always_comb
  begin
    next_sleep_sync = rst_i ? '0 : {sleep_sync[0], sleep_i};
  end

  always_ff @(posedge clk_i)
  begin
    sleep_sync <= next_sleep_sync;
  end

  // choose which gating set is in effect
  always_comb
  begin
    sleep_units = word_to_units(sleep_gating_reg);
    // sleep bits only count with auto gating on
    sleep_active = sleep_sync[scgr_pkg::SYNC_STAGES-1]
                   & auto_clock_gating; // see R10
    // outside sleep the run-mode enables stay in charge
    wanted_enable = sleep_active ? sleep_units : run_enable_i; // see R9
  end

  // registered enables: the faults and the gates use the same view
  always_comb
  begin
    next_enable_q = rst_i ? '0 : wanted_enable; // see R8
  end

  always_ff @(posedge clk_i)
  begin
    enable_q <= next_enable_q;
  end

  // per-unit clock gate
  genvar g;
  generate
    for (g = 0; g < UNITS; g++)
    begin : gen_gate
      scgr_clk_gate u_gate
      (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(enable_q[g]), // see R6
        .gclk_o(unit_clk_o[g])
      );
    end
  endgenerate

  // an access to an unclocked unit is refused with a fault
  assign unit_fault_o = unit_access_i & ~enable_q; // see R7
  assign unit_enable_o = enable_q;

  // level interrupt while an unmasked fault bit is set
  assign irq_o = |(fault_status & fault_mask);

  // bus answer: one registered ack or err per request
  always_comb
  begin
    next_bus_state = scgr_pkg::SCGR_IDLE;
    case (bus_state)
      scgr_pkg::SCGR_IDLE:
      begin
        if (bus_req)
        begin
          // unmapped addresses get err so software sees the slip
          next_bus_state = hit_any ? scgr_pkg::SCGR_ACK
                                   : scgr_pkg::SCGR_ERR;
        end
      end
      // answer lasts one cycle, then the master must release
      scgr_pkg::SCGR_ACK: next_bus_state = scgr_pkg::SCGR_IDLE;
      scgr_pkg::SCGR_ERR: next_bus_state = scgr_pkg::SCGR_IDLE;
      default: next_bus_state = scgr_pkg::SCGR_IDLE;
    endcase
    if (rst_i)
    begin
      next_bus_state = scgr_pkg::SCGR_IDLE;
    end
  end

  always_ff @(posedge clk_i)
  begin
    bus_state <= next_bus_state;
  end

  // read data captured with the request, held while answering
  always_comb
  begin
    next_rd_data = rd_data;
    if (rst_i)
    begin
      next_rd_data = scgr_pkg::ZERO_WORD;
    end
    else if (bus_req)
    begin
      next_rd_data = scgr_pkg::ZERO_WORD;
      if (!wb_we_i)
      begin
        if (hit_ctrl)
        begin
          next_rd_data[scgr_pkg::AUTO_CLOCK_GATING_BIT] = auto_clock_gating;
          next_rd_data[scgr_pkg::SLEEP_STATUS_BIT] = sleep_active;
        end
        if (hit_status)
        begin
          next_rd_data = units_to_word(fault_status);
        end
        if (hit_mask)
        begin
          next_rd_data = units_to_word(fault_mask);
        end
        if (hit_active)
        begin
          next_rd_data = units_to_word(enable_q);
        end
        if (hit_sleep)
        begin
          next_rd_data = sleep_gating_reg; // see R1
        end
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    rd_data <= next_rd_data;
  end

  // answer outputs; ack and err drop the cycle after they rise
  assign wb_ack_o = (bus_state == scgr_pkg::SCGR_ACK);
  assign wb_err_o = (bus_state == scgr_pkg::SCGR_ERR);
  assign wb_dat_o = rd_data;

endmodule : scgr_sleep_gate

// [scgr_pkg.sv]
// constants, register map and types of the sleep clock gating block
//
// Behaviour
// R1: reserved bits 31, 29, 27:8 read zero
// R2: software preserves reserved bits on read-modify-write
// R3: bit 30 gates the phy clock
// R4: bit 28 gates the mac clock
// R5: bits 7 to 0 gate ports h to a
// R6: set bit clocks unit, clear bit stops it
// R7: access to an unclocked unit gives bus fault
// R8: every gating bit resets to zero
// R9: sleep gating bits apply during sleep
// R10: sleep settings only used when auto gating set
// R11: sleep gating register at offset 0x118, reset zero
// R12: gated clocks switch only on clean boundaries
package scgr_pkg;

  // bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int SEL_W = 4;

  // register byte addresses
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 12'h000;
  localparam logic [ADDR_W-1:0] FAULT_STATUS_OFFSET = 12'h004;
  localparam logic [ADDR_W-1:0] FAULT_MASK_OFFSET = 12'h008;
  localparam logic [ADDR_W-1:0] ACTIVE_OFFSET = 12'h00c;
  localparam logic [ADDR_W-1:0] SLEEP_GATING_OFFSET = 12'h118;

  // reset values
  localparam logic [DATA_W-1:0] SLEEP_GATING_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

  // writable bits of the sleep gating register; the rest read zero
  localparam logic [DATA_W-1:0] SLEEP_GATING_WMASK = 32'h5000_00ff;

  // field positions in the sleep gating register
  localparam int PHY_CLOCK_GATE_BIT = 30;
  localparam int MAC_CLOCK_GATE_BIT = 28;
  localparam int PORT_A_CLOCK_GATE_BIT = 0;
  localparam int PORT_H_CLOCK_GATE_BIT = 7;

  // unit numbering on the unit-side vectors: ports a..h, mac, phy
  localparam int UNIT_N = 10;
  localparam int PORT_N = 8;
  localparam int UNIT_MAC = 8;
  localparam int UNIT_PHY = 9;

  // control register fields
  localparam int AUTO_CLOCK_GATING_BIT = 0;
  localparam int SLEEP_STATUS_BIT = 1;

  // two-flop synchroniser depth
  localparam int SYNC_STAGES = 2;

  // bus answer states
  typedef enum logic [1:0]
  {
    SCGR_IDLE,
    SCGR_ACK,
    SCGR_ERR
  } scgr_bus_state_t;

endpackage : scgr_pkg

// [scgr_clk_gate.sv]
// glitch-free clock gate cell for one controlled unit
`timescale 1ns/10ps
module scgr_clk_gate
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // gate request and gated clock
  input wire logic en_i,
  output logic gclk_o
);

  logic en_low;
  logic next_en_low;

  // enable only moves while the clock is low
  always_comb
  begin
    next_en_low = rst_i ? 1'b0 : en_i;
  end

  // falling-edge capture keeps the high phase whole
  always_ff @(negedge clk_i)
  begin
    en_low <= next_en_low; // see R12
  end

  assign gclk_o = clk_i & en_low; // see R6

endmodule : scgr_clk_gate

// [scgr_sleep_gate_assertions.sv]
// checker for the sleep clock gating block ports
`timescale 1ns/10ps
module scgr_sleep_gate_assertions
#(
  parameter int UNITS = 10
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  // power state and units
  input wire logic sleep_i,
  input wire logic [UNITS-1:0] run_enable_i,
  input wire logic [UNITS-1:0] unit_access_i,
  input wire logic [UNITS-1:0] unit_fault_o,
  input wire logic [UNITS-1:0] unit_enable_o,
  input wire logic [UNITS-1:0] unit_clk_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a request is only taken while the slave is not answering
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  sequence s_unmapped;
    s_req ##0 !(wb_adr_i inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h118});
  endsequence
  sequence s_gate_read;
    s_req ##0 (!wb_we_i && wb_adr_i == 12'h118);
  endsequence
  property p_answer;
    s_req |=> wb_ack_o != wb_err_o;
  endproperty
  property p_unmapped;
    s_unmapped |=> wb_err_o && !wb_ack_o;
  endproperty
  property p_pulse;
    wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o;
  endproperty
  property p_rsv_zero;
    s_gate_read |=> (wb_dat_o & ~scgr_pkg::SLEEP_GATING_WMASK) == 32'h0;
  endproperty
  property p_fault;
    unit_fault_o == (unit_access_i & ~unit_enable_o);
  endproperty
  // awake long enough for the synchroniser: run enables rule
  property p_run_path;
    (!sleep_i)[*4] |-> unit_enable_o == $past(run_enable_i);
  endproperty
  // gated clocks are low just before every rising edge: no runt pulse
  property p_gclk_low;
    unit_clk_o == '0;
  endproperty
  // interrupt moves only after a fault or a register write
  property p_irq_hold;
    !(|unit_fault_o) && !(wb_cyc_i && wb_stb_i && wb_we_i) |=> $stable(irq_o);
  endproperty
  property p_reset_exit;
    disable iff (1'b0) $fell(rst_i) |-> unit_enable_o == '0 && !irq_o;
  endproperty
  a_answer: assert property (p_answer)
    else $error("no single answer to request");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped address not refused");
  a_pulse: assert property (p_pulse)
    else $error("answer longer than one cycle");
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("reserved gating bits read nonzero");
  a_fault: assert property (p_fault)
    else $error("fault output wrong");
  a_run_path: assert property (p_run_path)
    else $error("awake enables differ from run enables");
  a_gclk_low: assert property (p_gclk_low)
    else $error("gated clock high at edge");
  a_irq_hold: assert property (p_irq_hold)
    else $error("interrupt changed without cause");
  a_reset_exit: assert property (p_reset_exit)
    else $error("state not cleared by reset");
endmodule : scgr_sleep_gate_assertions

// [scgr_sleep_gate_tb_top.sv]
// self-checking testbench of the sleep clock gating block
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module scgr_sleep_gate_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, wb_err_o, irq_o, e;
  logic sleep_i = 1'b0;
  logic [9:0] run_enable_i = 10'h000, unit_access_i = 10'h000;
  logic [9:0] unit_fault_o, unit_enable_o, unit_clk_o;
  int err_total = 0, cmp_count = 0, n_a = 0, n_b = 0;
  scgr_sleep_gate dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .sleep_i(sleep_i),
    .run_enable_i(run_enable_i), .unit_access_i(unit_access_i),
    .unit_fault_o(unit_fault_o), .unit_enable_o(unit_enable_o),
    .unit_clk_o(unit_clk_o), .irq_o(irq_o));
  // 25 MHz clock
  always #20 clk_i = ~clk_i;
  // gated clock edges of ports a and b
  always @(posedge unit_clk_o[0]) n_a++;
  always @(posedge unit_clk_o[1]) n_b++;
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  // one classic cycle; waits for ack or err under a bound
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= w;
    wb_adr_i <= a; wb_sel_i <= 4'hf; wb_dat_i <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      err_total++;
      complete_run();
    end
    q = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  // gating register bit of unit i: ports, mac, phy
  function automatic logic [31:0] gbit(input int i);
    return i < 8 ? 32'h1 << i : (i == 8 ? 32'h1000_0000 : 32'h4000_0000);
  endfunction : gbit
  initial
  begin
    cyc(4);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, 12'h118, 32'h0); `CHK(q, 32'h0000_0000)
    `CHK(unit_enable_o, 10'h000)
    wb(1'b0, 12'h010, 32'h0); `CHK(e, 1'b1)
    wb(1'b1, 12'h118, 32'hffff_ffff);
    wb(1'b0, 12'h118, 32'h0); `CHK(q, 32'h5000_00ff)
    // read-modify-write keeps the reserved bits as read
    wb(1'b1, 12'h118, q & ~32'h0000_0001);
    wb(1'b0, 12'h118, 32'h0); `CHK(q, 32'h5000_00fe)
    $display("register test done");
    // sleep with auto gating: each bit drives its own unit only
    wb(1'b1, 12'h000, 32'h1);
    sleep_i <= 1'b1;
    run_enable_i <= 10'h3ff;
    for (int i = 0; i < 10; i++)
    begin
      wb(1'b1, 12'h118, gbit(i));
      cyc(4);
      `CHK(unit_enable_o, 10'h1 << i)
    end
    // control shows auto gating on and the sleep set in effect
    wb(1'b0, 12'h000, 32'h0); `CHK(q, 32'h0000_0003)
    wb(1'b1, 12'h118, 32'h0000_0001);
    cyc(4);
    n_a = 0;
    n_b = 0;
    cyc(10);
    `CHK(n_a > 8 && n_a < 12, 1'b1)
    `CHK(n_b, 0)
    $display("gating test done");
    // auto gating off: run enables hold even in sleep
    run_enable_i <= 10'h2aa;
    wb(1'b1, 12'h000, 32'h0);
    cyc(4);
    `CHK(unit_enable_o, 10'h2aa)
    sleep_i <= 1'b0;
    wb(1'b1, 12'h000, 32'h1);
    cyc(4);
    `CHK(unit_enable_o, 10'h2aa)
    $display("mode test done");
    // port a unclocked and unmasked, port b clocked
    wb(1'b1, 12'h008, 32'h1);
    unit_access_i <= 10'h003;
    @(posedge clk_i);
    `CHK(unit_fault_o, 10'h001)
    unit_access_i <= 10'h000;
    cyc(2);
    `CHK(irq_o, 1'b1)
    wb(1'b0, 12'h004, 32'h0); `CHK(q, 32'h0000_0001)
    wb(1'b1, 12'h004, 32'h1); `CHK(irq_o, 1'b0)
    // port c fault is masked off: status only
    unit_access_i <= 10'h004;
    @(posedge clk_i);
    unit_access_i <= 10'h000;
    cyc(3);
    `CHK(irq_o, 1'b0)
    wb(1'b0, 12'h004, 32'h0); `CHK(q, 32'h0000_0004)
    $display("fault test done");
    complete_run();
  end
endmodule : scgr_sleep_gate_tb_top
bind scgr_sleep_gate scgr_sleep_gate_assertions #(.UNITS(UNITS)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o), .sleep_i(sleep_i), .run_enable_i(run_enable_i),
  .unit_access_i(unit_access_i), .unit_fault_o(unit_fault_o),
  .unit_enable_o(unit_enable_o), .unit_clk_o(unit_clk_o), .irq_o(irq_o));
